// >>> hdl/etie_cal_lut.sv
// Voltage-to-time calibration table, one write port and one registered read port
module etie_cal_lut import etie_pkg::*; (
    // Clock
    input wire logic i_clk_sys,
    // Load port
    input wire logic i_we,
    input wire logic [CODE_W-1:0] i_waddr,
    input wire logic [FINE_W-1:0] i_wdata,
    // Lookup port
    input wire logic [CODE_W-1:0] i_raddr,
    output logic [FINE_W-1:0] o_rdata
);
    // No reset on purpose: a block RAM cannot be cleared in one cycle
    logic [FINE_W-1:0] mem [LUT_DEPTH];

    always_ff @(posedge i_clk_sys) begin
        if (i_we) begin
            mem[i_waddr] <= i_wdata;
        end
        o_rdata <= mem[i_raddr];
    end
endmodule // etie_cal_lut

// >>> hdl/etie_path.sv
// One nth-event counter with the interpolator ramp it launches
module etie_path import etie_pkg::*; (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Sequencer side
    etie_path_if.path p
);
    logic [CNT_W-1:0] seen;
    logic launched;
    logic [1:0] ticks;
    logic [CNT_W-1:0] seen_next;
    logic hit;
    logic last_tick;

    assign seen_next = seen + CNT_W'(1);
    assign hit = p.arm && !launched && p.evt && (seen_next == p.target);
    assign last_tick = (ticks == RAMP_TICK_LAST);
    assign p.stop_now = p.ramp_run && p.tick && last_tick;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || p.clr) begin
            seen <= '0;
            launched <= 1'b0;
            ticks <= '0;
            p.ramp_run <= 1'b0;
            p.conv_req <= 1'b0;
            p.done <= 1'b0;
            p.code <= '0;
        end else begin
            if (p.arm && !launched && p.evt) begin
                seen <= seen_next;
            end
            // Tick in the launch cycle is not counted: charge lasts over one period
            if (hit) begin
                launched <= 1'b1;
                p.ramp_run <= 1'b1;
                ticks <= '0;
            end else if (p.ramp_run && p.tick) begin
                ticks <= ticks + 2'h1;
                if (last_tick) begin
                    p.ramp_run <= 1'b0;
                end
            end
            if (p.stop_now) begin
                p.conv_req <= 1'b1;
            end else if (p.conv_req && p.conv_done) begin
                p.conv_req <= 1'b0;
                p.done <= 1'b1;
                p.code <= p.conv_code;
            end
        end
    end

    AST_LAUNCH: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (hit && !p.clr) |=> p.ramp_run && launched)
        else $error("Ramp not launched on nth event");
    AST_RAMP_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (p.ramp_run && !p.tick && !p.clr) |=> p.ramp_run)
        else $error("Ramp ended without a time base edge");
    AST_RAMP_STOP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (p.ramp_run && p.tick && ticks == RAMP_TICK_LAST && !p.clr) |=> !p.ramp_run && p.conv_req)
        else $error("Ramp not stopped on second time base edge");
    AST_CONV_STORE: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (p.conv_req && p.conv_done && !p.clr) |=> p.done && p.code == $past(p.conv_code))
        else $error("Converted ramp level not captured");
    AST_CLEAR: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        p.clr |=> !p.done && !p.ramp_run && !p.conv_req && seen == '0)
        else $error("Path not cleared before measurement");
endmodule // etie_path

// >>> hdl/etie_path_if.sv
// Link between the sequencer and one counter/ramp path
interface etie_path_if import etie_pkg::*;;
    logic clr;
    logic arm;
    logic [CNT_W-1:0] target;
    logic evt;
    logic tick;
    logic conv_done;
    logic [CODE_W-1:0] conv_code;
    logic ramp_run;
    logic conv_req;
    logic stop_now;
    logic done;
    logic [CODE_W-1:0] code;

    modport ctl (output clr, arm, target, evt, tick, conv_done, conv_code,
                 input ramp_run, conv_req, stop_now, done, code);
    modport path (input clr, arm, target, evt, tick, conv_done, conv_code,
                  output ramp_run, conv_req, stop_now, done, code);
endinterface

// >>> hdl/etie_pkg.sv
// Constants, types and shared arithmetic of the edge time interval engine
package etie_pkg;

    // Time base
    localparam int TB_FREQ_MHZ = 200;
    localparam int TB_PERIOD_NS = 5;
    localparam longint TB_PERIOD_FS = longint'(TB_PERIOD_NS) * 64'd1000000;
    localparam int RAMP_STOP_TICKS = 2;
    localparam logic [1:0] RAMP_TICK_LAST = 2'(RAMP_STOP_TICKS - 1);

    // Coarse range: longest start-to-stop separation
    localparam longint MAX_SEP_S = 2;
    localparam longint MAX_SEP_NS = MAX_SEP_S * 64'd1000000000;
    localparam int COARSE_W = $clog2(MAX_SEP_NS / TB_PERIOD_NS + 1);

    // Calibration table
    localparam int LUT_SPAN_NS = 5;
    localparam int LUT_BINS_MIN = 41000;
    localparam int BIN_MAX_FS = 100;
    localparam int CODE_W = $clog2(LUT_BINS_MIN);
    localparam int LUT_DEPTH = 1 << CODE_W;
    localparam int FINE_W = 24;

    // Paths, counters, results
    localparam int NPATH = 3;
    localparam int CNT_W = 16;
    localparam int BURST_W = 16;
    localparam int RES_W = 56;
    localparam int SUM_W = RES_W + BURST_W;
    localparam int SQ_W = 128;
    localparam logic [CNT_W-1:0] N_FIRST = 16'h0001;
    localparam logic [CNT_W-1:0] N_SECOND = 16'h0002;
    localparam logic [CNT_W-1:0] N_THIRD = 16'h0003;

    typedef enum logic [1:0] {
        MODE_PERIOD = 2'h0,
        MODE_C2C = 2'h1,
        MODE_MOD = 2'h2
    } etie_mode_t;

    typedef enum logic [5:0] {
        ST_IDLE = 6'h01,
        ST_ARM = 6'h02,
        ST_MEAS = 6'h04,
        ST_LOOK = 6'h08,
        ST_CALC = 6'h10,
        ST_STORE = 6'h20
    } etie_state_t;

    // Interval between two ramps: later fine minus earlier fine plus whole periods
    function automatic logic signed [RES_W-1:0] etie_span(input logic [FINE_W-1:0] t_a,
            input logic [FINE_W-1:0] t_b, input logic [COARSE_W-1:0] c);
        etie_span = $signed(RES_W'(t_b)) - $signed(RES_W'(t_a)) + $signed(RES_W'(c) * RES_W'(TB_PERIOD_FS));
    endfunction

endpackage

// >>> hdl/etie_top.sv
// Time interval measurement engine for one comparator channel
// Operation
// - Each event counter counts comparator edges and launches its ramp when it reaches its programmed count.
// - Period mode programs the first counter to one and the second to two.
// - Start and stop events each launch their own ramp, and only the time base ends a ramp.
// - A ramp stops on the second rising time base edge after its launch.
// - A stopped ramp is digitised and its code is turned into a fine time through the calibration table.
// - The calibration table spreads the usable 5 ns ramp span over more than 41000 bins under 100 fs apart.
// - A coarse counter counts whole time base cycles between the start ramp and the stop ramp.
// - The coarse counter covers separations up to 2 seconds.
// - A result is stop fine time minus start fine time plus 5 ns times the coarse count.
// - A start ramp and a stop ramp that end on the same time base edge get a zero coarse count.
// - Cycle-to-cycle mode uses three counters at one, two and three and reports the difference of the two periods.
// - Modulation mode raises the stop count after each histogram up to the final count.
// - A burst of results is gathered into count, sum, sum of squares, maximum, minimum and peak-to-peak.
module etie_top import etie_pkg::*; (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Burst control
    input wire logic i_start,
    input wire logic [1:0] i_mode,
    input wire logic [BURST_W-1:0] i_burst_len,
    input wire logic [CNT_W-1:0] i_mod_final,
    // Comparator and time base
    input wire logic i_evt,
    input wire logic i_tb_tick,
    // Ramps and converter
    output logic [NPATH-1:0] o_ramp_run,
    output logic [NPATH-1:0] o_conv_req,
    input wire logic [NPATH-1:0] i_conv_done,
    input wire logic [NPATH-1:0][CODE_W-1:0] i_conv_code,
    // Calibration load
    input wire logic i_cal_we,
    input wire logic [CODE_W-1:0] i_cal_addr,
    input wire logic [FINE_W-1:0] i_cal_data,
    // Results
    output logic o_busy,
    output logic o_result_valid,
    output logic signed [RES_W-1:0] o_result,
    output logic [CNT_W-1:0] o_stop_n,
    output logic o_hist_done,
    output logic [BURST_W-1:0] o_hist_count,
    output logic signed [RES_W-1:0] o_hist_min,
    output logic signed [RES_W-1:0] o_hist_max,
    output logic [RES_W-1:0] o_hist_p2p,
    output logic signed [SUM_W-1:0] o_hist_sum,
    output logic [SQ_W-1:0] o_hist_sumsq
);
    etie_state_t state;
    etie_state_t next_state;
    etie_mode_t mode;
    logic [BURST_W-1:0] burst_len;
    logic [CNT_W-1:0] mod_final;

    // Comparator input synchroniser and edge filter
    logic evt_s1;
    logic evt_s2;
    logic evt_s3;
    logic evt_lvl;
    logic evt_rise;
    assign evt_rise = (evt_s2 == evt_s3) && evt_s3 && !evt_lvl;

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            evt_s1 <= 1'b0;
            evt_s2 <= 1'b0;
            evt_s3 <= 1'b0;
            evt_lvl <= 1'b0;
        end else begin
            evt_s1 <= i_evt;
            evt_s2 <= evt_s1;
            evt_s3 <= evt_s2;
            if (evt_s2 == evt_s3) begin
                evt_lvl <= evt_s3;
            end
        end
    end

    // Path programming
    logic use3;
    logic [NPATH-1:0] path_used;
    logic [CNT_W-1:0] tgt [NPATH];
    assign use3 = (mode == MODE_C2C);
    assign path_used = {use3, 1'b1, 1'b1};
    assign tgt[0] = N_FIRST;
    assign tgt[1] = (mode == MODE_MOD) ? o_stop_n : N_SECOND;
    assign tgt[2] = N_THIRD;

    logic [NPATH-1:0] done_a;
    logic [NPATH-1:0] stop_a;
    logic [NPATH-1:0] ramp_a;
    logic [NPATH-1:0] req_a;
    logic [CODE_W-1:0] code_a [NPATH];

    etie_path_if pif[NPATH] ();

    for (genvar g = 0; g < NPATH; g++) begin : g_path
        assign pif[g].clr = (state == ST_ARM);
        assign pif[g].arm = (state == ST_MEAS) && path_used[g];
        assign pif[g].target = tgt[g];
        assign pif[g].evt = evt_rise;
        assign pif[g].tick = i_tb_tick;
        assign pif[g].conv_done = i_conv_done[g];
        assign pif[g].conv_code = i_conv_code[g];
        assign done_a[g] = pif[g].done;
        assign stop_a[g] = pif[g].stop_now;
        assign ramp_a[g] = pif[g].ramp_run;
        assign req_a[g] = pif[g].conv_req;
        assign code_a[g] = pif[g].code;
        etie_path u_path (
            .i_clk_sys(i_clk_sys),
            .i_rst_n(i_rst_n),
            .p(pif[g].path)
        );
    end

    assign o_ramp_run = ramp_a;
    assign o_conv_req = req_a;

    logic all_done;
    assign all_done = &(done_a | ~path_used);

    // Coarse count from the start ramp stop to each later ramp stop
    logic [COARSE_W-1:0] coarse;
    logic coarse_run;
    logic [COARSE_W-1:0] coarse_now;
    logic [COARSE_W-1:0] snap1;
    logic [COARSE_W-1:0] snap2;
    assign coarse_now = coarse + COARSE_W'(coarse_run && i_tb_tick);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || state == ST_ARM) begin
            coarse <= '0;
            coarse_run <= 1'b0;
            snap1 <= '0;
            snap2 <= '0;
        end else if (state == ST_MEAS) begin
            // Same-tick stops see coarse_run low, so short intervals get zero
            if (stop_a[0]) begin
                coarse_run <= 1'b1;
            end
            if (coarse_run && i_tb_tick) begin
                coarse <= coarse_now;
            end
            if (stop_a[1]) begin
                snap1 <= coarse_now;
            end
            if (stop_a[2]) begin
                snap2 <= coarse_now;
            end
        end
    end

    // Calibration lookup, one path at a time
    logic [1:0] lidx;
    logic lk_wait;
    logic lk_last;
    logic [CODE_W-1:0] lut_raddr;
    logic [FINE_W-1:0] lut_rdata;
    logic [FINE_W-1:0] fine [NPATH];
    assign lut_raddr = code_a[lidx];
    assign lk_last = lk_wait && (lidx == (use3 ? 2'(NPATH - 1) : 2'(NPATH - 2)));

    etie_cal_lut u_lut (
        .i_clk_sys(i_clk_sys),
        .i_we(i_cal_we),
        .i_waddr(i_cal_addr),
        .i_wdata(i_cal_data),
        .i_raddr(lut_raddr),
        .o_rdata(lut_rdata)
    );

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n || state != ST_LOOK) begin
            lidx <= '0;
            lk_wait <= 1'b0;
        end else if (!lk_wait) begin
            lk_wait <= 1'b1;
        end else begin
            fine[lidx] <= lut_rdata;
            lidx <= lidx + 2'h1;
            lk_wait <= 1'b0;
        end
    end

    // Result arithmetic
    logic signed [RES_W-1:0] per1;
    logic signed [RES_W-1:0] per2;
    logic signed [RES_W-1:0] next_result;
    assign per1 = etie_span(fine[0], fine[1], snap1);
    assign per2 = etie_span(fine[1], fine[2], snap2 - snap1);
    assign next_result = use3 ? (per2 - per1) : per1;

    // Histogram accumulation
    logic [BURST_W-1:0] count_next;
    logic hist_last;
    logic mod_step;
    logic first;
    logic signed [RES_W-1:0] next_min;
    logic signed [RES_W-1:0] next_max;
    logic signed [2*RES_W-1:0] sq;
    assign count_next = o_hist_count + BURST_W'(1);
    assign hist_last = (count_next == burst_len);
    assign mod_step = hist_last && (mode == MODE_MOD) && (o_stop_n < mod_final);
    assign first = (o_hist_count == '0);
    assign next_min = (first || o_result < o_hist_min) ? o_result : o_hist_min;
    assign next_max = (first || o_result > o_hist_max) ? o_result : o_hist_max;
    assign sq = o_result * o_result;

    always_comb begin
        case (state)
            ST_IDLE: next_state = i_start ? ST_ARM : ST_IDLE;
            ST_ARM: next_state = ST_MEAS;
            ST_MEAS: next_state = all_done ? ST_LOOK : ST_MEAS;
            ST_LOOK: next_state = lk_last ? ST_CALC : ST_LOOK;
            ST_CALC: next_state = ST_STORE;
            ST_STORE: next_state = (hist_last && !mod_step) ? ST_IDLE : ST_ARM;
            default: next_state = ST_IDLE;
        endcase
    end

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            state <= ST_IDLE;
            mode <= MODE_PERIOD;
            burst_len <= '0;
            mod_final <= '0;
        end else begin
            state <= next_state;
            if (state == ST_IDLE && i_start) begin
                mode <= etie_mode_t'(i_mode);
                burst_len <= i_burst_len;
                mod_final <= i_mod_final;
            end
        end
    end

    logic hist_clear;
    // Cleared on the re-arm after a full histogram, so each finished one stands at its done pulse
    assign hist_clear = (state == ST_IDLE && i_start) || (state == ST_ARM && o_hist_count == burst_len);

    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            o_busy <= 1'b0;
            o_result_valid <= 1'b0;
            o_result <= '0;
            o_stop_n <= N_SECOND;
            o_hist_done <= 1'b0;
            o_hist_count <= '0;
            o_hist_min <= '0;
            o_hist_max <= '0;
            o_hist_p2p <= '0;
            o_hist_sum <= '0;
            o_hist_sumsq <= '0;
        end else begin
            o_busy <= (next_state != ST_IDLE);
            o_result_valid <= (state == ST_CALC);
            o_hist_done <= (state == ST_STORE) && hist_last;
            if (state == ST_CALC) begin
                o_result <= next_result;
            end
            if (state == ST_IDLE && i_start) begin
                o_stop_n <= N_SECOND;
            end else if (state == ST_STORE && mod_step) begin
                o_stop_n <= o_stop_n + CNT_W'(1);
            end
            // Statistics are left standing after the last result for software to read
            if (hist_clear) begin
                o_hist_count <= '0;
                o_hist_min <= '0;
                o_hist_max <= '0;
                o_hist_p2p <= '0;
                o_hist_sum <= '0;
                o_hist_sumsq <= '0;
            end else if (state == ST_STORE) begin
                o_hist_count <= count_next;
                o_hist_min <= next_min;
                o_hist_max <= next_max;
                o_hist_p2p <= RES_W'(next_max - next_min);
                o_hist_sum <= o_hist_sum + SUM_W'(o_result);
                o_hist_sumsq <= o_hist_sumsq + SQ_W'(sq);
            end
        end
    end

    AST_PERIOD_TARGETS: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == ST_MEAS && mode == MODE_PERIOD) |-> tgt[0] == N_FIRST && tgt[1] == N_SECOND && !use3)
        else $error("Period mode counters not at one and two");
    AST_COARSE_HOLD: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == ST_MEAS && !i_tb_tick) |=> coarse == $past(coarse))
        else $error("Coarse count moved without a time base edge");
    AST_SHORT_ZERO: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == ST_MEAS && stop_a[0] && stop_a[1]) |=> snap1 == '0)
        else $error("Short interval got a coarse count");
    AST_RESULT_SUM: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == ST_CALC && mode != MODE_C2C) |=>
            o_result_valid && o_result == etie_span(fine[0], fine[1], snap1))
        else $error("Interval result does not match fine and coarse parts");
    AST_C2C_SETUP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == ST_MEAS && mode == MODE_C2C) |->
            path_used == 3'h7 && tgt[0] == N_FIRST && tgt[1] == N_SECOND && tgt[2] == N_THIRD)
        else $error("Cycle-to-cycle paths not set to one, two and three");
    AST_MOD_STEP: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == ST_STORE && mod_step) |=> o_stop_n == $past(o_stop_n) + CNT_W'(1) && state == ST_ARM)
        else $error("Stop count not advanced after histogram");
    AST_HIST_COUNT: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == ST_STORE) |=> o_hist_count == $past(o_hist_count) + BURST_W'(1))
        else $error("Histogram count not advanced on stored result");
    AST_REARM: assert property (@(posedge i_clk_sys) disable iff (!i_rst_n)
        (state == ST_ARM) |-> ($past(state) == ST_IDLE || $past(state) == ST_STORE))
        else $error("Re-armed before result was stored");
endmodule // etie_top

// >>> tb/etie_far_end.sv
// Far-side model: comparator edges, time base strobe and converter
module etie_far_end import etie_pkg::*; (
    // Clock and reset
    input wire logic i_clk_sys,
    input wire logic i_rst_n,
    // Stimulus settings
    input wire logic [7:0] i_gap,
    input wire logic i_slow,
    // Comparator and time base
    output logic o_evt,
    output logic o_tb_tick,
    // Converter
    input wire logic [NPATH-1:0] i_conv_req,
    output logic [NPATH-1:0] o_conv_done,
    output logic [NPATH-1:0][CODE_W-1:0] o_conv_code
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [7:0] ecnt;
    logic tph;
    logic [NPATH-1:0] sent;
    logic [NPATH-1:0][2:0] wt;
    always_ff @(posedge i_clk_sys) begin
        if (!i_rst_n) begin
            ecnt <= 8'h00;
            tph <= 1'b0;
        end else begin
            tph <= ~tph;
            ecnt <= (ecnt + 8'h01 >= i_gap) ? 8'h00 : ecnt + 8'h01;
        end
    end
    // Half-high edge train; tick at the closest spacing allowed
    assign o_evt = ecnt < (i_gap >> 1);
    assign o_tb_tick = tph;
    always_ff @(posedge i_clk_sys) begin
        for (int p = 0; p < NPATH; p++) begin
            o_conv_done[p] <= 1'b0;
            if (!i_rst_n || !i_conv_req[p]) begin
                wt[p] <= 3'h0;
                sent[p] <= 1'b0;
            end else if (!sent[p]) begin
                if (wt[p] == (i_slow ? 3'h5 : 3'h1)) begin
                    o_conv_done[p] <= 1'b1;
                    sent[p] <= 1'b1;
                end else begin
                    wt[p] <= wt[p] + 3'h1;
                end
            end
        end
    end
    // Code inverted outside done so a stale value never looks valid
    always_comb begin
        for (int p = 0; p < NPATH; p++) begin
            o_conv_code[p] = o_conv_done[p] ? CODE_W'(16 * (p + 1)) : ~CODE_W'(16 * (p + 1));
        end
    end
endmodule // etie_far_end

// >>> tb/tb.sv
// Self-checking bench for the edge time interval engine
`define CHK(nm, ex, got) begin compares++; if ((got) !== (ex)) begin fails++; $display("[FAIL] %s exp %0d got %0d", nm, ex, got); end end
module tb;
    timeunit 1ns;
    timeprecision 1ps;
    import etie_pkg::*;
    localparam longint F0 = 1000;
    localparam longint F1 = 3500;
    localparam longint F2 = 2200;
    localparam longint P = 5000000;
    logic i_clk_sys = 1'b0;
    logic i_rst_n = 1'b0;
    logic i_start = 1'b0;
    logic [1:0] i_mode = 2'h0;
    logic [BURST_W-1:0] i_burst_len = 16'h0001;
    logic [CNT_W-1:0] i_mod_final = 16'h0002;
    logic i_cal_we = 1'b0;
    logic [CODE_W-1:0] i_cal_addr = 16'h0000;
    logic [FINE_W-1:0] i_cal_data = 24'h000000;
    logic i_evt, i_tb_tick, o_busy, o_result_valid, o_hist_done;
    logic [NPATH-1:0] o_ramp_run, o_conv_req, i_conv_done;
    logic [NPATH-1:0][CODE_W-1:0] i_conv_code;
    logic signed [RES_W-1:0] o_result, o_hist_min, o_hist_max;
    logic [RES_W-1:0] o_hist_p2p;
    logic [CNT_W-1:0] o_stop_n;
    logic [BURST_W-1:0] o_hist_count;
    logic signed [SUM_W-1:0] o_hist_sum;
    logic [SQ_W-1:0] o_hist_sumsq;
    logic [7:0] gap = 8'h06;
    logic slow = 1'b0;
    int fails = 0;
    int compares = 0;
    int hd = 0;
    int rw = 0;
    logic signed [RES_W-1:0] res_q[$];
    logic [CNT_W-1:0] stop_q[$];

    always #5 i_clk_sys = ~i_clk_sys;

    etie_top u_etie_top (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_start(i_start), .i_mode(i_mode),
        .i_burst_len(i_burst_len), .i_mod_final(i_mod_final), .i_evt(i_evt), .i_tb_tick(i_tb_tick),
        .o_ramp_run(o_ramp_run), .o_conv_req(o_conv_req), .i_conv_done(i_conv_done),
        .i_conv_code(i_conv_code), .i_cal_we(i_cal_we), .i_cal_addr(i_cal_addr), .i_cal_data(i_cal_data),
        .o_busy(o_busy), .o_result_valid(o_result_valid), .o_result(o_result), .o_stop_n(o_stop_n),
        .o_hist_done(o_hist_done), .o_hist_count(o_hist_count), .o_hist_min(o_hist_min),
        .o_hist_max(o_hist_max), .o_hist_p2p(o_hist_p2p), .o_hist_sum(o_hist_sum), .o_hist_sumsq(o_hist_sumsq));
    etie_far_end u_etie_far_end (.i_clk_sys(i_clk_sys), .i_rst_n(i_rst_n), .i_gap(gap), .i_slow(slow),
        .o_evt(i_evt), .o_tb_tick(i_tb_tick), .i_conv_req(o_conv_req), .o_conv_done(i_conv_done),
        .o_conv_code(i_conv_code));

    task automatic step();
        @(posedge i_clk_sys);
        #1;
    endtask

    always @(posedge i_clk_sys) begin
        if (o_result_valid === 1'b1) begin
            res_q.push_back(o_result);
            stop_q.push_back(o_stop_n);
        end
        if (o_hist_done === 1'b1) begin
            hd++;
            `CHK("hd_count", i_burst_len, o_hist_count)
        end
        if (o_ramp_run[0] === 1'b1) rw++;
        else if (rw != 0) begin
            // Registered span: one and a half to two tick periods (3 to 4 cycles), ticks two cycles apart
            `CHK("ramp_width", 1'b1, 1'(rw >= 3 && rw <= 4))
            rw = 0;
        end
    end

    task automatic complete_run();
        $display("compares %0d fails %0d", compares, fails);
        if (fails == 0 && compares > 0) $display("*** PASS ***");
        else $display("*** FAIL ***");
        $finish;
    endtask

    task automatic cal_load(input logic [CODE_W-1:0] a, input longint d);
        i_cal_we = 1'b1;
        i_cal_addr = a;
        i_cal_data = FINE_W'(d);
        step();
    endtask

    task automatic run(input logic [1:0] m, input logic [15:0] n, input logic [15:0] fin, input int nh);
        int t;
        t = 0;
        hd = 0;
        res_q.delete();
        stop_q.delete();
        i_mode = m;
        i_burst_len = n;
        i_mod_final = fin;
        i_start = 1'b1;
        step();
        i_start = 1'b0;
        while (!(hd == nh && o_busy === 1'b0) && t < 20000) begin
            step();
            t++;
        end
        if (t >= 20000) begin
            fails++;
            complete_run();
        end
        // No extra measurement may slip in before each store
        `CHK("results", int'(n) * nh, res_q.size())
    endtask

    task automatic t_period(input logic [7:0] g, input logic s, input logic [15:0] n);
        longint v;
        gap = g;
        slow = s;
        v = F1 - F0 + P * (g / 2);
        run(2'h0, n, 16'h0002, 1);
        foreach (res_q[i]) `CHK("period", RES_W'(v), res_q[i])
        `CHK("h_count", n, o_hist_count)
        `CHK("h_min", RES_W'(v), o_hist_min)
        `CHK("h_max", RES_W'(v), o_hist_max)
        `CHK("h_p2p", RES_W'(0), o_hist_p2p)
        `CHK("h_sum", SUM_W'(v * n), o_hist_sum)
        `CHK("h_sumsq", SQ_W'(v * v * n), o_hist_sumsq)
        $display("test period done");
    endtask

    task automatic t_c2c();
        gap = 8'h06;
        slow = 1'b0;
        run(2'h1, 16'h0002, 16'h0002, 1);
        foreach (res_q[i]) `CHK("c2c", RES_W'((F2 - F1) - (F1 - F0)), res_q[i])
        $display("test c2c done");
    endtask

    task automatic t_mod();
        gap = 8'h04;
        run(2'h2, 16'h0001, 16'h0004, 3);
        foreach (res_q[i]) begin
            `CHK("mod_stop", CNT_W'(i + 2), stop_q[i])
            `CHK("mod_res", RES_W'(F1 - F0 + P * 2 * (i + 1)), res_q[i])
        end
        `CHK("mod_count", 16'h0001, o_hist_count)
        $display("test modulation done");
    endtask

    initial begin
        repeat (6) @(posedge i_clk_sys);
        #1;
        i_rst_n = 1'b1;
        `CHK("stop_rst", N_SECOND, o_stop_n)
        `CHK("busy_rst", 1'b0, o_busy)
        `CHK("ramp_rst", 3'h0, o_ramp_run)
        `CHK("coarse_w", 1'b1, 1'(COARSE_W >= 29))
        `CHK("lut_bins", 1'b1, 1'(LUT_DEPTH > 41000))
        cal_load(16'h0010, F0);
        cal_load(16'h0020, F1);
        cal_load(16'h0030, F2);
        i_cal_we = 1'b0;
        step();
        t_period(8'h06, 1'b0, 16'h0003);
        t_period(8'h04, 1'b1, 16'h0001);
        t_c2c();
        t_mod();
        complete_run();
    end
endmodule // tb
